// ---- sar_pkg.sv ----
// Package with constants and carrier types for the serial SAR readout block
package sar_pkg;

  // ----------------------------------------------------------------
  // Resolution and sequence figures
  // ----------------------------------------------------------------
  localparam int SAR_RES_BITS = 12;   // Result width, two's complement
  localparam int SAR_ACQ_FALLS = 2;   // Falling serial clock edges spent acquiring
  localparam int SAR_CODE_STEPS = 4096; // Steps across 2*Vref span

  // Reset and null-bit values of the serial output
  localparam logic SAR_DOUT_RST = 1'h0;
  localparam logic SAR_NULL_BIT = 1'h0; // Low null bit ahead of the result

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Host-driven serial pins, sampled on the system clock
  typedef struct packed {
    logic cs_n;          // Active-low chip select
    logic serial_clock;  // Host serial clock
  } sar_link_t;

  // Three-state form of the data output pin
  typedef struct packed {
    logic data;          // Level driven while enabled
    logic oe;            // High while the block drives the pin
  } sar_dout_t;

  // Readout sequence states
  typedef enum logic [2:0] {
    SAR_IDLE,
    SAR_ACQUIRE,
    SAR_NULL,
    SAR_CONVERT,
    SAR_REVERSE,
    SAR_DONE
  } sar_state_t;

endpackage

// ---- sar_adc_serial_readout.sv ----
// Serial readout and successive-approximation sequencer of a differential converter
// Functional notes
// - Output changes only on serial clock falls and on chip select high.
// - Chip select falling starts conversion and transfer.
// - First two serial periods acquire the input.
// - After second fall, enable output, low null.
// - Next twelve periods send result MSB first.
// - After LSB, resend the bits above it, lowest first.
// - After MSB resent, float output, ignore clocks.
// - Restart needs chip select high then low.
// - Result coded twelve-bit two's complement.
// - One step is two Vref over 4096.
// - Bits belong to current conversion, no latency.
// - Chip select high aborts and floats output.
`timescale 1ns/1ns

module sar_adc_serial_readout
  import sar_pkg::*;
#(
  parameter int RES_BITS = SAR_RES_BITS
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire sar_link_t link_in,
  input wire logic comp_above,
  output logic sample_hold,
  output logic [RES_BITS-1:0] dac_code,
  output sar_dout_t dout,
  output logic [RES_BITS-1:0] result
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The bit pointer and sequence below assume at least two bits
  if (RES_BITS < 2 || RES_BITS > 16)
  begin : g_bad_res
    $error("sar_adc_serial_readout: RES_BITS must lie in 2..16");
  end

  localparam int IDX_W = $clog2(RES_BITS + 1);
  localparam logic [IDX_W-1:0] IDX_MSB = IDX_W'(RES_BITS - 1);
  localparam logic [IDX_W-1:0] IDX_END = IDX_W'(RES_BITS);
  localparam logic [IDX_W-1:0] IDX_ZERO = '0;
  localparam logic [IDX_W-1:0] IDX_ONE = IDX_W'(1);
  localparam logic [1:0] ACQ_LAST = 2'(SAR_ACQ_FALLS - 1);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One-hot mask of a bit position
  function automatic logic [RES_BITS-1:0] bit_mask(input logic [IDX_W-1:0] idx);
    bit_mask = '0;
    bit_mask[idx] = 1'h1;
  endfunction

  // Offset-binary decision to two's complement bit: only the MSB flips
  function automatic logic twos_bit(input logic decided, input logic [IDX_W-1:0] idx);
    twos_bit = (idx == IDX_MSB) ? ~decided : decided;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sar_state_t state_reg; // Sequence state
  logic cs_n_prev_reg; // Chip select one clock ago
  logic sclk_prev_reg; // Serial clock one clock ago
  logic [1:0] acq_cnt_reg; // Falls seen while acquiring
  logic [IDX_W-1:0] idx_reg; // Bit under test or being resent
  logic [RES_BITS-1:0] sar_reg; // Offset-binary kept decisions
  logic [RES_BITS-1:0] result_reg; // Two's complement result
  logic dout_data_reg; // Serial data level
  logic dout_oe_reg; // Serial output enable
  logic cs_fall; // Chip select went low
  logic sclk_fall; // Serial clock went low
  logic decided_bit; // Two's complement bit decided this fall

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Pins arrive synchronous, so one stage of history is enough
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_n_prev_reg <= 1'h1;
      sclk_prev_reg <= 1'h0;
    end
    else
    begin
      cs_n_prev_reg <= link_in.cs_n;
      sclk_prev_reg <= link_in.serial_clock;
    end
  end

  assign cs_fall = cs_n_prev_reg & ~link_in.cs_n;
  assign sclk_fall = sclk_prev_reg & ~link_in.serial_clock;
  assign decided_bit = twos_bit(comp_above, idx_reg);

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  // Chip select high wins over everything and parks the sequencer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SAR_IDLE;
    end
    else if (link_in.cs_n)
    begin
      state_reg <= SAR_IDLE;
    end
    else
    begin
      unique case (state_reg)
        SAR_IDLE:
        begin
          // Only a select fall starts; low select after DONE does not
          if (cs_fall)
          begin
            state_reg <= SAR_ACQUIRE;
          end
        end
        SAR_ACQUIRE:
        begin
          if (sclk_fall && acq_cnt_reg == ACQ_LAST)
          begin
            state_reg <= SAR_NULL;
          end
        end
        SAR_NULL:
        begin
          if (sclk_fall)
          begin
            state_reg <= SAR_CONVERT;
          end
        end
        SAR_CONVERT:
        begin
          if (sclk_fall && idx_reg == IDX_ZERO)
          begin
            state_reg <= SAR_REVERSE;
          end
        end
        SAR_REVERSE:
        begin
          if (sclk_fall && idx_reg == IDX_END)
          begin
            state_reg <= SAR_DONE;
          end
        end
        SAR_DONE:
        begin
          // Further clocks have no effect until select rises
          state_reg <= SAR_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Acquisition counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acq_cnt_reg <= '0;
    end
    else if (state_reg != SAR_ACQUIRE)
    begin
      acq_cnt_reg <= '0;
    end
    else if (sclk_fall)
    begin
      acq_cnt_reg <= acq_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Bit pointer
  // ----------------------------------------------------------------
  // Counts down while resolving, then up while resending
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_reg <= IDX_MSB;
    end
    else if (state_reg == SAR_IDLE || state_reg == SAR_ACQUIRE)
    begin
      idx_reg <= IDX_MSB;
    end
    else if (sclk_fall && (state_reg == SAR_NULL || state_reg == SAR_CONVERT))
    begin
      // The fall that ends the null bit already decides the MSB
      idx_reg <= (idx_reg == IDX_ZERO) ? IDX_ONE : idx_reg - IDX_ONE;
    end
    else if (sclk_fall && state_reg == SAR_REVERSE && idx_reg != IDX_END)
    begin
      idx_reg <= idx_reg + IDX_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Approximation and result registers
  // ----------------------------------------------------------------
  // Decisions are latched on the same fall that puts them on the pin
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar_reg <= '0;
      result_reg <= '0;
    end
    else if (state_reg == SAR_ACQUIRE)
    begin
      sar_reg <= '0;
      result_reg <= '0;
    end
    else if (sclk_fall && (state_reg == SAR_NULL || state_reg == SAR_CONVERT))
    begin
      // Deciding the MSB here puts it on the pin on the fall after the null bit
      if (comp_above)
      begin
        sar_reg <= sar_reg | bit_mask(idx_reg);
      end
      result_reg[idx_reg] <= decided_bit;
    end
  end

  // Trial code: kept bits plus the bit under test, LSB = 2*Vref/4096
  always_comb
  begin
    dac_code = sar_reg;
    if (state_reg == SAR_NULL || state_reg == SAR_CONVERT)
    begin
      dac_code = sar_reg | bit_mask(idx_reg);
    end
  end

  // ----------------------------------------------------------------
  // Serial data output
  // ----------------------------------------------------------------
  // Every update is gated by a serial clock fall, except the float on chip select high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_data_reg <= SAR_DOUT_RST;
      dout_oe_reg <= 1'h0;
    end
    else if (link_in.cs_n)
    begin
      dout_data_reg <= SAR_DOUT_RST;
      dout_oe_reg <= 1'h0;
    end
    else if (sclk_fall)
    begin
      unique case (state_reg)
        SAR_ACQUIRE:
        begin
          if (acq_cnt_reg == ACQ_LAST)
          begin
            dout_data_reg <= SAR_NULL_BIT;
            dout_oe_reg <= 1'h1;
          end
        end
        SAR_NULL, SAR_CONVERT:
        begin
          // Bit shown as soon as decided, no pipeline
          dout_data_reg <= decided_bit;
        end
        SAR_REVERSE:
        begin
          if (idx_reg == IDX_END)
          begin
            dout_oe_reg <= 1'h0;
            dout_data_reg <= SAR_DOUT_RST;
          end
          else
          begin
            dout_data_reg <= result_reg[idx_reg];
          end
        end
        default:
        begin
          dout_oe_reg <= dout_oe_reg;
        end
      endcase
    end
  end

  assign dout.data = dout_data_reg;
  assign dout.oe = dout_oe_reg;
  assign result = result_reg;
  assign sample_hold = (state_reg == SAR_ACQUIRE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_change_on_fall;
    @(posedge clock) disable iff (!rst_n)
      (!link_in.cs_n && $changed(dout_data_reg)) |-> $past(sclk_fall);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall)
    else $error("serial data changed without a serial clock fall");

  property p_start;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_IDLE && cs_fall) |=> (state_reg == SAR_ACQUIRE && sample_hold);
  endproperty
  a_start: assert property (p_start)
    else $error("select fall did not start acquisition");

  property p_null;
    @(posedge clock) disable iff (!rst_n)
      $rose(dout_oe_reg) |-> (dout_data_reg == SAR_NULL_BIT && state_reg == SAR_NULL);
  endproperty
  a_null: assert property (p_null)
    else $error("output enabled without a low null bit");

  property p_acq_len;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_NULL && $past(state_reg) == SAR_ACQUIRE) |-> $past(acq_cnt_reg) == ACQ_LAST;
  endproperty
  a_acq_len: assert property (p_acq_len)
    else $error("acquisition left before the second fall");

  property p_msb_first;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_NULL && sclk_fall && !link_in.cs_n)
        |=> (dout_data_reg == ~$past(comp_above) && idx_reg == IDX_MSB - IDX_ONE);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("MSB not shown inverted on the fall after the null bit");

  property p_no_latency;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_CONVERT && sclk_fall && !link_in.cs_n)
        |=> dout_data_reg == result_reg[$past(idx_reg)];
  endproperty
  a_no_latency: assert property (p_no_latency)
    else $error("shown bit differs from the bit just decided");

  property p_reverse;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_REVERSE && sclk_fall && !link_in.cs_n && idx_reg != IDX_END)
        |=> (dout_data_reg == result_reg[$past(idx_reg)] && dout_oe_reg);
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("reversed resend shows the wrong bit");

  property p_float_done;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_DONE) |-> (!dout_oe_reg && sar_reg == $past(sar_reg));
  endproperty
  a_float_done: assert property (p_float_done)
    else $error("output driven or state moved after the sequence ended");

  property p_no_restart;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == SAR_DONE && !link_in.cs_n) |=> state_reg == SAR_DONE;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("clocking alone restarted a conversion");

  property p_abort;
    @(posedge clock) disable iff (!rst_n)
      link_in.cs_n |=> (state_reg == SAR_IDLE && !dout_oe_reg);
  endproperty
  a_abort: assert property (p_abort)
    else $error("select high did not abort and float");

endmodule

// ---- sar_host_model.sv ----
// Host serial controller and analog front end facing the readout block
`timescale 1ns/1ns

module sar_host_model
  import sar_pkg::*;
(
  input wire logic clock,
  output sar_link_t link,
  output logic comp_above,
  input wire logic sample_hold,
  input wire logic [SAR_RES_BITS-1:0] dac_code,
  input wire sar_dout_t dout
);
  // ----------------------------------------------------------------
  // Captured state of one frame
  // ----------------------------------------------------------------
  logic [SAR_RES_BITS-1:0] tgt; // Two's complement code the input maps to
  logic [1:0] cap [0:31]; // Oe and data seen after each serial fall
  logic sh_acq; // Sample/hold seen during acquisition
  logic sh_conv; // Sample/hold seen once bits are resolving
  logic [SAR_RES_BITS-1:0] dac_null; // Trial code seen during the null bit

  initial
  begin
    link.cs_n = 1'h1;
    link.serial_clock = 1'h0;
    tgt = '0;
  end

  // Ideal comparator: one code step per 2*Vref/4096, offset binary DAC
  assign comp_above = ({~tgt[SAR_RES_BITS-1], tgt[SAR_RES_BITS-2:0]} >= dac_code);

  // ----------------------------------------------------------------
  // One frame: n serial periods, then select high again
  // ----------------------------------------------------------------
  // Serial clock is 2 system clocks high, 2 low, and stands low between frames
  task automatic frame(input int n, input logic [SAR_RES_BITS-1:0] t);
    tgt = t;
    @(posedge clock);
    link.cs_n <= 1'h0;
    repeat (2) @(posedge clock);
    sh_acq = sample_hold;
    for (int k = 1; k <= n; k++)
    begin
      @(posedge clock);
      link.serial_clock <= 1'h1;
      // Capture on the rising serial edge, bit settled since the fall
      cap[k-1] = {dout.oe, dout.data};
      if (k == 4)
        sh_conv = sample_hold;
      if (k == 3)
        dac_null = dac_code;
      @(posedge clock);
      @(posedge clock);
      link.serial_clock <= 1'h0;
      @(posedge clock);
    end
    @(posedge clock);
    cap[n] = {dout.oe, dout.data};
    // Early rise aborts a short read; always return high before next frame
    link.cs_n <= 1'h1;
    repeat (4) @(posedge clock);
  endtask
endmodule

// ---- sar_adc_serial_readout_test.sv ----
// Self-checking testbench of the serial SAR readout block
`timescale 1ns/1ns

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module sar_adc_serial_readout_test;
  import sar_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic clock; // 25 MHz system clock
  logic rst_n; // Async reset, active low
  sar_link_t link; // From host model
  logic comp_above; // Comparator decision
  logic sample_hold; // Acquisition indicator
  logic [SAR_RES_BITS-1:0] dac_code; // Trial code
  sar_dout_t dout; // Data pin in three-state form
  logic [SAR_RES_BITS-1:0] result; // Decided bits
  int fail_count;
  int n_compared;
  logic [SAR_RES_BITS-1:0] t; // Code under test
  int n; // Serial periods in a frame
  logic [SAR_RES_BITS-1:0] corner [0:3]; // Full scale, zero, minus one, minus full
  // First trial code: only the MSB set, half the span
  localparam logic [SAR_RES_BITS-1:0] MSB_TRIAL = SAR_RES_BITS'(1) << (SAR_RES_BITS - 1);

  sar_adc_serial_readout dut (
    .clock(clock),
    .rst_n(rst_n),
    .link_in(link),
    .comp_above(comp_above),
    .sample_hold(sample_hold),
    .dac_code(dac_code),
    .dout(dout),
    .result(result)
  );

  sar_host_model host (
    .clock(clock),
    .link(link),
    .comp_above(comp_above),
    .sample_hold(sample_hold),
    .dac_code(dac_code),
    .dout(dout)
  );

  // ----------------------------------------------------------------
  // Expected pin state after serial fall k
  // ----------------------------------------------------------------
  // Falls 0..1 acquire, 2 null, 3..14 forward, 15..25 reverse, then float
  function automatic logic [1:0] exp_pin(input logic [SAR_RES_BITS-1:0] c, input int k);
    if (k < 2 || k > 25)
      return 2'h0;
    if (k == 2)
      return {1'h1, SAR_NULL_BIT};
    if (k <= 14)
      return {1'h1, c[14-k]};
    return {1'h1, c[k-14]};
  endfunction

  // Runs one frame and compares every captured bit
  task automatic run(input int nf, input logic [SAR_RES_BITS-1:0] c);
    host.frame(nf, c);
    `CHK(host.sh_acq, 1'h1)
    if (nf >= 4)
      `CHK(host.sh_conv, 1'h0)
    if (nf >= 3)
      `CHK(host.dac_null, MSB_TRIAL)
    for (int k = 0; k <= nf; k++)
      `CHK(host.cap[k], exp_pin(c, k))
    `CHK(dout.oe, 1'h0)
    if (nf >= 14)
      `CHK(result, c)
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    rst_n = 1'h0;
    corner[0] = 12'h7ff;
    corner[1] = 12'h000;
    corner[2] = 12'hfff;
    corner[3] = 12'h800;
    void'($urandom(32'hcbd3e85d));
    repeat (2) @(posedge clock);
    `CHK(dout.oe, 1'h0)
    rst_n <= 1'h1;
    @(posedge clock);
    // Corner codes, clocked well past the end to show later falls ignored
    for (int i = 0; i < 4; i++)
      run(30, corner[i]);
    // Random codes, exact full length back to back
    for (int i = 0; i < 6; i++)
    begin
      t = SAR_RES_BITS'($urandom);
      run(26, t);
    end
    // Short-cycled reads aborted at random bit positions
    for (int i = 0; i < 8; i++)
    begin
      t = SAR_RES_BITS'($urandom);
      n = 3 + ($urandom % 23);
      run(n, t);
    end
    report_and_stop();
  end

  // Bound on the whole run
  initial
  begin
    #2000000;
    fail_count++;
    report_and_stop();
  end
endmodule
